// >>> bench/ppc_gate_drv.sv
// Behavioural gate driver pair loading the high-side and low-side pins.
`timescale 1ns/1ps
module ppc_gate_drv (
    input wire logic i_high,
    input wire logic i_low,
    output logic o_gate_high,
    output logic o_gate_low,
    output logic o_both_on
);
    // Both gates on at once would short the bridge leg, so it is flagged.
    assign o_gate_high = i_high;
    assign o_gate_low = i_low;
    assign o_both_on = i_high && i_low;
endmodule

// >>> bench/ppc_pin_control_checker.sv
// Checker for bus timing, reset and module-disable behaviour at the pin stage ports.
`timescale 1ns/1ps
module ppc_pin_control_checker (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ppc_pkg::APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_high_side_output,
    input wire logic o_low_side_output,
    input wire logic o_module_active
);
    import ppc_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    wire logic acc = i_psel && i_penable;
    wire logic aux_wr = o_pready && acc && i_pwrite && i_paddr == OFS_AUX_CTRL;
    sequence access_s; acc && !o_pready; endsequence
    sequence answer_s; o_pready ##1 !o_pready; endsequence
    answer_one_a: assert property (access_s |=> answer_s)
        else $error("bus answer not a single wait state");
    err_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error flag without ready");
    unmapped_err_a: assert property (o_pready && acc && i_paddr > OFS_STATUS |-> o_pslverr)
        else $error("unmapped access not flagged");
    idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    reset_state_a: assert property ($rose(i_rstn) |-> !o_module_active && !o_high_side_output
        && !o_low_side_output ##1 o_module_active)
        else $error("bad state after reset");
    off_delay_a: assert property (aux_wr && i_pwdata[B_MODULE_DISABLE] |-> ##2 !o_module_active)
        else $error("module not disabled in time");
    on_delay_a: assert property (aux_wr && !i_pwdata[B_MODULE_DISABLE] |-> ##2 o_module_active)
        else $error("module not enabled in time");
    pins_frozen_a: assert property (!o_module_active |=> $stable(o_high_side_output)
        && $stable(o_low_side_output))
        else $error("pins moved while disabled");
    off_read_a: assert property (o_pready && acc && !o_module_active && i_paddr != OFS_AUX_CTRL
        |-> o_prdata == 32'h0)
        else $error("disabled read not zero");
endmodule
bind ppc_pin_control ppc_pin_control_checker chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_high_side_output(o_high_side_output), .o_low_side_output(o_low_side_output),
    .o_module_active(o_module_active));

// >>> bench/ppc_pin_control_test.sv
// Self-checking bench for the PWM pin output stage.
`timescale 1ns/1ps
module ppc_pin_control_test;
    import ppc_pkg::*;
    logic clk, rstn, psel, pen, pwr, ph, pl, flt, clim, gh, gl, rdy, err, serr;
    logic pin_h, pin_l, act, gate_h, gate_l, both, cs;
    logic [APB_AW-1:0] addr;
    logic [31:0] wdata, rdata, rd;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    ppc_pin_control DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy),
        .o_pslverr(err), .i_pwm_high(ph), .i_pwm_low(pl), .i_cycle_start(cs),
        .i_fault_active(flt), .i_climit_active(clim), .i_gpio_high(gh), .i_gpio_low(gl),
        .o_high_side_output(pin_h), .o_low_side_output(pin_l), .o_module_active(act));
    ppc_gate_drv drv (.i_high(pin_h), .i_low(pin_l), .o_gate_high(gate_h),
        .o_gate_low(gate_l), .o_both_on(both));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            give_verdict();
        end
    end
    // The request is held until ready is seen at an edge; data is taken at that edge.
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk iff rdy);
        rd = rdata;
        serr = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word(rd, exp);
    endtask
    // Override bits pass their own flop before the pin flop, so three edges let a setting land.
    task automatic chk_pins(input logic [1:0] exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check_count++;
        if ({gate_h, gate_l, both} !== {exp, &exp}) begin
            mismatches++;
            $display("ERROR %0t pins %b expected %b", $time, {gate_h, gate_l, both}, exp);
        end
    endtask
    task automatic cfg(input logic [15:0] v, input logic [1:0] pwm, input logic [1:0] fc);
        // The generator enable lives outside this block, so each call stands for a stopped generator.
        apb(1'b1, OFS_PIN_CTRL, {16'h0, v});
        {ph, pl} <= pwm;
        {flt, clim} <= fc;
    endtask
    initial begin
        {rstn, psel, pen, pwr, ph, pl, flt, clim, gh, gl, cs} = '0;
        addr = '0;
        wdata = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(OFS_PIN_CTRL, 32'h0000c000);
        rd_chk(OFS_AUX_CTRL, 32'h0);
        apb(1'b1, OFS_PIN_CTRL, 32'hfffffffc);
        rd_chk(OFS_PIN_CTRL, 32'h0000fffc);
        rd_chk(12'h00c, 32'h0);
        chk_word({31'h0, serr}, 32'h1);
        $display("test registers done");
        cfg(16'h8000, 2'b01, 2'b00);
        {gh, gl} <= 2'b11;
        chk_pins(2'b01);
        cfg(16'h4000, 2'b01, 2'b00);
        chk_pins(2'b11);
        for (int m = 0; m < 4; m++) begin
            for (int k = 1; k < 4; k += 2) begin
                cfg({4'hc, m[1:0], 10'h0}, k[1:0], 2'b00);
                chk_pins({k[1], m == 0 ? ~k[1] : (m == 1 ? k[1] : k[0])});
            end
        end
        cfg(16'hfc00, 2'b10, 2'b00);
        chk_pins(2'b01);
        cfg(16'hcf80, 2'b01, 2'b00);
        chk_pins(2'b10);
        cfg(16'hce80, 2'b01, 2'b00);
        chk_pins(2'b11);
        cfg(16'hcd00, 2'b11, 2'b00);
        chk_pins(2'b10);
        $display("test pin paths done");
        cfg(16'hcc20, 2'b01, 2'b10);
        chk_pins(2'b10);
        rd_chk(OFS_STATUS, 32'h00000015);
        cfg(16'hfc20, 2'b01, 2'b10);
        chk_pins(2'b01);
        cfg(16'hcc04, 2'b10, 2'b01);
        chk_pins(2'b01);
        apb(1'b1, OFS_AUX_CTRL, 32'h1);
        cfg(16'hcc20, 2'b01, 2'b01);
        chk_pins(2'b11);
        cfg(16'hcc20, 2'b01, 2'b10);
        chk_pins(2'b00);
        apb(1'b1, OFS_AUX_CTRL, 32'h0);
        cfg(16'hcc02, 2'b10, 2'b00);
        chk_pins(2'b01);
        cfg(16'hcf81, 2'b01, 2'b00);
        chk_pins(2'b01);
        @(posedge clk);
        cs <= 1'b1;
        @(posedge clk);
        cs <= 1'b0;
        chk_pins(2'b10);
        $display("test forcing done");
        cfg(16'hcc00, 2'b10, 2'b00);
        apb(1'b1, OFS_AUX_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        chk_word({31'h0, act}, 32'h0);
        apb(1'b1, OFS_PIN_CTRL, 32'h0);
        {ph, pl} <= 2'b01;
        chk_pins(2'b10);
        rd_chk(OFS_PIN_CTRL, 32'h0);
        rd_chk(OFS_AUX_CTRL, 32'h2);
        apb(1'b1, OFS_AUX_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        rd_chk(OFS_PIN_CTRL, 32'h0000cc00);
        chk_pins(2'b01);
        $display("test module disable done");
        apb(1'b1, OFS_AUX_CTRL, 32'h1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(OFS_AUX_CTRL, 32'h0);
        rd_chk(OFS_PIN_CTRL, 32'h0000c000);
        chk_word({31'h0, act}, 32'h1);
        chk_pins(2'b01);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule

// >>> verilog/ppc_pin_control.sv
// Top of the PWM pin output stage with its APB register slave.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - High ownership bit set: PWM drives high pin; clear: GPIO drives it.
// - Low ownership bit set: PWM drives low pin; clear: GPIO drives it.
// - High polarity bit set makes the high pin active-low.
// - Low polarity bit set makes the low pin active-low.
// - Pair mode: 11 independent, 10 push-pull, 01 redundant, 00 complementary.
// - High override enable puts upper override data on the high pin.
// - Low override enable puts lower override data on the low pin.
// - Override data: upper bit for high pin, lower bit for low pin.
// - Normal fault mode: fault forces both pins to the fault data bits.
// - Independent mode: current limit forces high pin, fault forces low pin.
// - Forced states are active levels, translated through each pin's polarity.
// - Module disable freezes the block, ignores writes, reads return zero, except for the auxiliary control register.
// - Disable and re-enable take effect one cycle after the write.
// - Reset leaves module disable clear; block runs only when present and enabled.
module ppc_pin_control #(
    parameter bit PRESENT = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ppc_pkg::APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_pwm_high,
    input wire logic i_pwm_low,
    input wire logic i_cycle_start,
    input wire logic i_fault_active,
    input wire logic i_climit_active,
    input wire logic i_gpio_high,
    input wire logic i_gpio_low,
    output logic o_high_side_output,
    output logic o_low_side_output,
    output logic o_module_active
);
    import ppc_pkg::*;

    logic [15:0] pin_ctrl_reg;
    logic [1:0] aux_ctrl_reg;
    logic active_reg;
    logic [3:0] ovr_reg;
    logic [3:0] ovr_next;
    logic pin_h_reg;
    logic pin_l_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rdata_next;

    ppc_stage_if st ();

    // APB decode: one wait state, so every access completes in its second access cycle.
    wire access = i_psel & i_penable;
    wire done = access & pready_reg;
    wire hit_pin = i_paddr == OFS_PIN_CTRL;
    wire hit_aux = i_paddr == OFS_AUX_CTRL;
    wire hit_st = i_paddr == OFS_STATUS;
    wire mapped = hit_pin | hit_aux | hit_st;
    wire wr_pin = done & i_pwrite & hit_pin & active_reg;
    wire wr_aux = done & i_pwrite & hit_aux;
    wire [ST_W-1:0] status = {active_reg, i_climit_active, i_fault_active, pin_l_reg, pin_h_reg};

    always_comb begin
        rdata_next = 32'h0;
        if (hit_aux) begin
            rdata_next = {30'h0, aux_ctrl_reg};
        end else if (hit_pin & active_reg) begin
            rdata_next = {16'h0, pin_ctrl_reg};
        end else if (hit_st & active_reg) begin
            rdata_next = {27'h0, status};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~mapped;
            prdata_reg <= (access & ~pready_reg & ~i_pwrite) ? rdata_next : 32'h0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            pin_ctrl_reg <= PIN_CTRL_RESET;
        end else if (wr_pin) begin
            pin_ctrl_reg <= i_pwdata[15:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            aux_ctrl_reg <= AUX_CTRL_RESET;
        end else if (wr_aux) begin
            aux_ctrl_reg <= i_pwdata[1:0];
        end
    end

    // The disable bit acts through this flop, so the change lands one cycle after the write.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= PRESENT & ~aux_ctrl_reg[B_MODULE_DISABLE];
        end
    end

    // With override sync set, override changes wait for the next cycle start to avoid runts.
    wire [3:0] ovr_cfg = {pin_ctrl_reg[B_HIGH_OVR_EN], pin_ctrl_reg[B_LOW_OVR_EN],
        pin_ctrl_reg[B_OVR_DATA_HI], pin_ctrl_reg[B_OVR_DATA_LO]};
    assign ovr_next = (~pin_ctrl_reg[B_OVR_SYNC] | i_cycle_start) ? ovr_cfg : ovr_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            ovr_reg <= 4'h0;
        end else if (active_reg) begin
            ovr_reg <= ovr_next;
        end
    end

    assign st.cfg = pin_ctrl_reg;
    assign st.ovr_en_h = ovr_reg[3];
    assign st.ovr_en_l = ovr_reg[2];
    assign st.ovr_dat_h = ovr_reg[1];
    assign st.ovr_dat_l = ovr_reg[0];
    assign st.indep_fault = aux_ctrl_reg[B_INDEP_FAULT];
    assign st.pwm_h = i_pwm_high;
    assign st.pwm_l = i_pwm_low;
    assign st.fault = i_fault_active;
    assign st.clim = i_climit_active;
    assign st.gpio_h = i_gpio_high;
    assign st.gpio_l = i_gpio_low;

    ppc_pin_mux u_mux (
        .st(st)
    );

    // A disabled module stops updating its pin flops, so its pins hold their last level.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            pin_h_reg <= 1'b0;
            pin_l_reg <= 1'b0;
        end else if (active_reg) begin
            pin_h_reg <= st.pin_h;
            pin_l_reg <= st.pin_l;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_high_side_output = pin_h_reg;
    assign o_low_side_output = pin_l_reg;
    assign o_module_active = active_reg;
endmodule

// >>> verilog/ppc_pin_mux.sv
// Combinational pin-pair mode, override, fault forcing, polarity and ownership selection.
`timescale 1ns/1ps
module ppc_pin_mux (
    ppc_stage_if.mux st
);
    import ppc_pkg::*;

    // Active level to pin level: an active-low pin inverts.
    function automatic logic to_pin(input logic active, input logic pol_low);
        to_pin = active ^ pol_low;
    endfunction

    wire [1:0] mode = st.cfg[B_MODE_HI:B_MODE_LO];
    logic pair_h;
    logic pair_l;

    always_comb begin
        unique case (ppc_mode_e'(mode))
            PPC_MODE_COMPL: begin
                pair_h = st.pwm_h;
                pair_l = ~st.pwm_h;
            end
            PPC_MODE_REDUND: begin
                pair_h = st.pwm_h;
                pair_l = st.pwm_h;
            end
            // Push-pull relies on the generator alternating its two waveforms per period.
            PPC_MODE_PUSHPULL: begin
                pair_h = st.pwm_h;
                pair_l = st.pwm_l;
            end
            PPC_MODE_INDEP: begin
                pair_h = st.pwm_h;
                pair_l = st.pwm_l;
            end
        endcase
    end

    wire swap = st.cfg[B_SWAP];
    wire gen_h = swap ? pair_l : pair_h;
    wire gen_l = swap ? pair_h : pair_l;
    wire ovr_h = st.ovr_en_h ? st.ovr_dat_h : gen_h;
    wire ovr_l = st.ovr_en_l ? st.ovr_dat_l : gen_l;

    // Fault outranks current limit; in independent mode each event owns one pin.
    wire force_h_flt = ~st.indep_fault & st.fault;
    wire force_h_clim = st.indep_fault ? st.clim : (st.clim & ~st.fault);
    wire force_l_flt = st.fault;
    wire force_l_clim = ~st.indep_fault & st.clim & ~st.fault;
    wire act_h = force_h_flt ? st.cfg[B_FAULT_DATA_HI] :
        force_h_clim ? (st.indep_fault ? st.cfg[B_FAULT_DATA_HI] : st.cfg[B_CLIM_DATA_HI]) :
        ovr_h;
    wire act_l = force_l_flt ? st.cfg[B_FAULT_DATA_LO] :
        force_l_clim ? st.cfg[B_CLIM_DATA_LO] : ovr_l;

    wire lvl_h = to_pin(act_h, st.cfg[B_HIGH_POL]);
    wire lvl_l = to_pin(act_l, st.cfg[B_LOW_POL]);

    assign st.pin_h = st.cfg[B_HIGH_OWN] ? lvl_h : st.gpio_h;
    assign st.pin_l = st.cfg[B_LOW_OWN] ? lvl_l : st.gpio_l;
endmodule

// >>> verilog/ppc_pkg.sv
// Package with register map, field positions and reset values of the PWM pin output stage.
package ppc_pkg;
    localparam int unsigned APB_AW = 12;
    localparam logic [APB_AW-1:0] OFS_PIN_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] OFS_AUX_CTRL = 12'h004;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h008;
    localparam logic [15:0] PIN_CTRL_RESET = 16'hc000;
    localparam logic [1:0] AUX_CTRL_RESET = 2'h0;
    // Fields of pwm_pin_output_control.
    localparam int unsigned B_HIGH_OWN = 15;
    localparam int unsigned B_LOW_OWN = 14;
    localparam int unsigned B_HIGH_POL = 13;
    localparam int unsigned B_LOW_POL = 12;
    localparam int unsigned B_MODE_HI = 11;
    localparam int unsigned B_MODE_LO = 10;
    localparam int unsigned B_HIGH_OVR_EN = 9;
    localparam int unsigned B_LOW_OVR_EN = 8;
    localparam int unsigned B_OVR_DATA_HI = 7;
    localparam int unsigned B_OVR_DATA_LO = 6;
    localparam int unsigned B_FAULT_DATA_HI = 5;
    localparam int unsigned B_FAULT_DATA_LO = 4;
    localparam int unsigned B_CLIM_DATA_HI = 3;
    localparam int unsigned B_CLIM_DATA_LO = 2;
    localparam int unsigned B_SWAP = 1;
    localparam int unsigned B_OVR_SYNC = 0;
    // Fields of the auxiliary control register.
    localparam int unsigned B_INDEP_FAULT = 0;
    localparam int unsigned B_MODULE_DISABLE = 1;
    // Fields of the status register.
    localparam int unsigned B_ST_HIGH_PIN = 0;
    localparam int unsigned B_ST_LOW_PIN = 1;
    localparam int unsigned B_ST_FAULT = 2;
    localparam int unsigned B_ST_CLIM = 3;
    localparam int unsigned B_ST_ACTIVE = 4;
    localparam int unsigned ST_W = 5;
    // Delay from a module-disable write to the change of state, in clock cycles.
    localparam int unsigned DISABLE_DELAY_CYC = 1;

    typedef enum logic [1:0] {
        PPC_MODE_COMPL = 2'b00,
        PPC_MODE_REDUND = 2'b01,
        PPC_MODE_PUSHPULL = 2'b10,
        PPC_MODE_INDEP = 2'b11
    } ppc_mode_e;
endpackage

// >>> verilog/ppc_stage_if.sv
// Interface carrying pin-stage settings and results between the control and the pin mux.
`timescale 1ns/1ps
interface ppc_stage_if;
    import ppc_pkg::*;
    logic [15:0] cfg;
    logic ovr_en_h;
    logic ovr_en_l;
    logic ovr_dat_h;
    logic ovr_dat_l;
    logic indep_fault;
    logic pwm_h;
    logic pwm_l;
    logic fault;
    logic clim;
    logic gpio_h;
    logic gpio_l;
    logic pin_h;
    logic pin_l;
    modport ctrl (output cfg, ovr_en_h, ovr_en_l, ovr_dat_h, ovr_dat_l, indep_fault, pwm_h,
        pwm_l, fault, clim, gpio_h, gpio_l, input pin_h, pin_l);
    modport mux (input cfg, ovr_en_h, ovr_en_l, ovr_dat_h, ovr_dat_l, indep_fault, pwm_h,
        pwm_l, fault, clim, gpio_h, gpio_l, output pin_h, pin_l);
endinterface
